//--- rtl/dpmf_regs.svh
// Named constants of the demand-priority end-node framer
`ifndef DPMF_REGS_SVH
`define DPMF_REGS_SVH
`define DPMF_TRAIN_LEN_MIN 10'd594
`define DPMF_TRAIN_LEN_MAX 10'd675
`define DPMF_PRIV_OCTETS 10'd55
`define DPMF_PRIV_ID_OCTETS 10'd5
`define DPMF_PRIV_IDX_OFS 10'd4
`define DPMF_TRAIN_GOOD_RUN 5'd24
`define DPMF_CRC_POLY 32'h04c11db7
`define DPMF_CRC_INIT 32'hffffffff
`define DPMF_CRC_RESIDUE 32'hc704dd7b
`define DPMF_ADDR_OCTETS 11'd6
`define DPMF_TRAIN_HDR_OCTETS 5'd16
`define DPMF_DATA_HDR_OCTETS 5'd12
`define DPMF_TR_HDR_OCTETS 5'd14
`define DPMF_FCS_LAST 10'd3
`define DPMF_ACFG_OCTET 11'd15
`define DPMF_ACFG_C_BIT 1
`define DPMF_ACFG_N_BIT 2
`define DPMF_RETRAIN_MS 1000
`define DPMF_CLK_KHZ 100000
`endif

//--- rtl/dpmf_pkg.sv
// Types shared by the demand-priority end-node framer
`default_nettype none
package dpmf_pkg;
  typedef enum logic [2:0] {
    TCS_IDLE_UP, TCS_REQ_NORMAL, TCS_REQ_HIGH, TCS_TRAINING_UP, TCS_TX_DISABLE
  } dpmf_tcs_t;
  typedef enum logic [2:0] {
    RCS_DATA_ON_LINK, RCS_IDLE_DOWN, RCS_INCOMING, RCS_LINK_WARNING,
    RCS_MODE_TRANSITION, RCS_TRAINING_DOWN
  } dpmf_rcs_t;
  typedef struct packed {
    dpmf_rcs_t rcs;
    logic grant;
  } dpmf_link_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } dpmf_byte_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic err;
    logic invalid_packet_marker;
  } dpmf_rx_t;
  typedef enum {
    ST_TREQ, ST_TGRANT, ST_TSEND, ST_TRECV, ST_TDONE, ST_RETRAIN,
    ST_ACTIVE, ST_DSEND, ST_DRECV
  } dpmf_state_t;
  typedef enum {PH_IDLE, PH_HDR, PH_DATA, PH_PAY, PH_FCS} dpmf_phase_t;
endpackage : dpmf_pkg
`default_nettype wire

//--- rtl/dpmf_framer.sv
// Demand-priority end-node framer: training, framing, check value, link control
`timescale 1ns/100ps
`default_nettype none
`include "dpmf_regs.svh"
module dpmf_framer
  import dpmf_pkg::*;
#(
  parameter int unsigned RETRAIN_CYCLES = `DPMF_RETRAIN_MS * `DPMF_CLK_KHZ,
  parameter int unsigned TRAIN_TRIES_MAX = 64
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [47:0] station_addr,
  input wire logic [15:0] req_cfg,
  input wire logic [9:0] train_len,
  input wire logic priv_en,
  input wire logic [39:0] priv_id,
  input wire logic [5:0] priv_used,
  input wire logic [7:0] priv_byte,
  input wire logic promisc,
  input wire logic cli_tx_req,
  input wire logic cli_tx_high,
  input wire logic cli_tx_fmt_tr,
  input wire logic [15:0] cli_tx_prefix,
  input wire logic [47:0] cli_tx_da,
  input wire logic cli_tx_sa_valid,
  input wire logic [47:0] cli_tx_sa,
  input wire dpmf_byte_t cli_tx,
  input wire dpmf_link_t link_in,
  input wire dpmf_rx_t rx_in,
  output logic cli_tx_ready_r,
  output logic [5:0] priv_idx_r,
  output dpmf_byte_t pmi_tx_r,
  output dpmf_tcs_t tcs_r,
  output logic rx_en_r,
  output dpmf_byte_t cli_rx_r,
  output logic cli_rx_good_r,
  output logic cli_rx_bad_r,
  output logic trained_r
);
  // ==========================================================
  // Functions
  // Bits enter least significant first; register bit 31 is x^31
  function automatic logic [31:0] dpmf_crc8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `DPMF_CRC_POLY : 32'h0);
    end
    return r;
  endfunction : dpmf_crc8

  function automatic logic [7:0] dpmf_fcs_octet(input logic [31:0] c, input logic [1:0] k);
    logic [7:0] o;
    o = 8'h0;
    for (int i = 0; i < 8; i++)
    begin
      o[i] = ~c[31 - 8 * int'(k) - i];
    end
    return o;
  endfunction : dpmf_fcs_octet

  function automatic logic [7:0] dpmf_octet(input logic [127:0] h, input logic [4:0] k);
    logic [127:0] s;
    s = h << (8 * int'(k));
    return s[127:120];
  endfunction : dpmf_octet

  // ==========================================================
  // Control state
  dpmf_state_t st_r;
  dpmf_phase_t ph_r;
  logic [9:0] cnt_r;
  logic [31:0] crc_r;
  logic [127:0] hdr_r;
  logic [4:0] hdr_len_r;
  logic train_r;
  logic grant_used_r;
  logic [4:0] run_r;
  logic [5:0] tries_r;
  logic [26:0] wait_r;
  logic [10:0] rx_cnt_r;
  logic [31:0] rx_crc_r;
  logic rx_bad_r;
  logic rx_da_ok_r;
  logic rx_grp_r;
  logic rx_void_r;
  logic [7:0] acfg_r;
  logic [9:0] len_eff;
  logic [7:0] train_octet;
  logic grant_ok;
  logic incoming;
  logic go_train;
  logic go_data;
  logic tx_done;
  logic rx_end;
  logic [31:0] rx_crc_nxt;
  logic da_hit;
  logic grp_nxt;
  logic frame_ok;
  logic deliver;
  logic [47:0] sa_sel;

  // ==========================================================
  // Decodes
  always_comb
  begin
    len_eff = train_len;
    if (train_len < `DPMF_TRAIN_LEN_MIN)
      len_eff = `DPMF_TRAIN_LEN_MIN;
    else if (train_len > `DPMF_TRAIN_LEN_MAX)
      len_eff = `DPMF_TRAIN_LEN_MAX;
    train_octet = 8'h0;
    if (priv_en && cnt_r < `DPMF_PRIV_ID_OCTETS)
      train_octet = dpmf_octet({priv_id, 88'h0}, cnt_r[4:0]);
    else if (priv_en && cnt_r < `DPMF_PRIV_OCTETS &&
             priv_idx_r < priv_used)
      train_octet = priv_byte;
  end

  // The grant flag is the sole send permission; each grant is spent once
  assign grant_ok = link_in.grant && !grant_used_r;
  assign incoming = link_in.rcs == RCS_INCOMING;
  assign go_train = st_r == ST_TGRANT && grant_ok && ph_r == PH_IDLE;
  assign go_data = st_r == ST_ACTIVE && !incoming && grant_ok &&
                   cli_tx_req && ph_r == PH_IDLE;
  assign tx_done = ph_r == PH_FCS && cnt_r == `DPMF_FCS_LAST;
  assign sa_sel = cli_tx_sa_valid ? cli_tx_sa : station_addr;

  // ==========================================================
  // Transmit engine
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ph_r <= PH_IDLE;
      cnt_r <= '0;
      crc_r <= `DPMF_CRC_INIT;
      hdr_r <= '0;
      hdr_len_r <= '0;
      train_r <= 1'b0;
      pmi_tx_r <= '0;
      cli_tx_ready_r <= 1'b0;
      priv_idx_r <= '0;
    end
    else
    begin
      pmi_tx_r <= '0;
      case (ph_r)
        PH_IDLE:
        begin
          cnt_r <= '0;
          crc_r <= `DPMF_CRC_INIT;
          if (go_train)
          begin
            // Null destination, then source and both configurations
            hdr_r <= {48'h0, station_addr, req_cfg, 16'h0};
            hdr_len_r <= `DPMF_TRAIN_HDR_OCTETS;
            train_r <= 1'b1;
            ph_r <= PH_HDR;
          end
          else if (go_data)
          begin
            hdr_r <= cli_tx_fmt_tr ? {cli_tx_prefix, cli_tx_da, sa_sel, 16'h0}
                                   : {cli_tx_da, sa_sel, 32'h0};
            hdr_len_r <= cli_tx_fmt_tr ? `DPMF_TR_HDR_OCTETS : `DPMF_DATA_HDR_OCTETS;
            train_r <= 1'b0;
            ph_r <= PH_HDR;
          end
        end
        PH_HDR:
        begin
          pmi_tx_r <= '{1'b1, dpmf_octet(hdr_r, cnt_r[4:0]), 1'b0};
          crc_r <= dpmf_crc8(crc_r, dpmf_octet(hdr_r, cnt_r[4:0]));
          cnt_r <= cnt_r + 10'd1;
          priv_idx_r <= '0;
          if (cnt_r[4:0] == hdr_len_r - 5'd1)
          begin
            cnt_r <= '0;
            ph_r <= train_r ? PH_DATA : PH_PAY;
            cli_tx_ready_r <= !train_r;
          end
        end
        PH_DATA:
        begin
          pmi_tx_r <= '{1'b1, train_octet, 1'b0};
          crc_r <= dpmf_crc8(crc_r, train_octet);
          cnt_r <= cnt_r + 10'd1;
          // Index of the private octet that the next count will need
          priv_idx_r <= 6'(cnt_r - `DPMF_PRIV_IDX_OFS);
          if (cnt_r == len_eff - 10'd1)
          begin
            cnt_r <= '0;
            ph_r <= PH_FCS;
          end
        end
        PH_PAY:
        begin
          // An empty client stream stalls the link with gaps, no buffering
          if (cli_tx.valid && cli_tx_ready_r)
          begin
            pmi_tx_r <= '{1'b1, cli_tx.data, 1'b0};
            crc_r <= dpmf_crc8(crc_r, cli_tx.data);
            if (cli_tx.last)
            begin
              cli_tx_ready_r <= 1'b0;
              cnt_r <= '0;
              ph_r <= PH_FCS;
            end
          end
        end
        PH_FCS:
        begin
          pmi_tx_r <= '{1'b1, dpmf_fcs_octet(crc_r, cnt_r[1:0]), tx_done};
          cnt_r <= cnt_r + 10'd1;
          if (tx_done)
            ph_r <= PH_IDLE;
        end
        default:
          ph_r <= PH_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Grant bookkeeping
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      grant_used_r <= 1'b0;
    else if (go_train || go_data)
      grant_used_r <= 1'b1;
    else if (!link_in.grant)
      grant_used_r <= 1'b0;
  end

  // ==========================================================
  // Receive checker
  assign rx_end = rx_in.valid && rx_in.last;
  assign rx_crc_nxt = dpmf_crc8(rx_crc_r, rx_in.data);
  assign grp_nxt = (rx_cnt_r == '0) ? rx_in.data[0] : rx_grp_r;
  assign da_hit = (rx_cnt_r >= `DPMF_ADDR_OCTETS) ||
                  rx_in.data == dpmf_octet({station_addr, 80'h0}, rx_cnt_r[4:0]);
  assign frame_ok = rx_crc_nxt == `DPMF_CRC_RESIDUE && !rx_bad_r &&
                    !rx_in.err && !rx_in.invalid_packet_marker;
  assign deliver = st_r == ST_ACTIVE || st_r == ST_DRECV;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rx_cnt_r <= '0;
      rx_crc_r <= `DPMF_CRC_INIT;
      rx_bad_r <= 1'b0;
      rx_da_ok_r <= 1'b1;
      rx_grp_r <= 1'b0;
      rx_void_r <= 1'b0;
      acfg_r <= '0;
      cli_rx_r <= '0;
      cli_rx_good_r <= 1'b0;
      cli_rx_bad_r <= 1'b0;
    end
    else
    begin
      cli_rx_r <= '0;
      cli_rx_good_r <= 1'b0;
      cli_rx_bad_r <= 1'b0;
      if (rx_in.valid)
      begin
        rx_crc_r <= rx_crc_nxt;
        rx_cnt_r <= (&rx_cnt_r) ? rx_cnt_r : rx_cnt_r + 11'd1;
        rx_bad_r <= rx_bad_r || rx_in.err || rx_in.invalid_packet_marker;
        rx_void_r <= rx_void_r || rx_in.invalid_packet_marker;
        rx_da_ok_r <= rx_da_ok_r && da_hit;
        rx_grp_r <= grp_nxt;
        if (rx_cnt_r == `DPMF_ACFG_OCTET)
          acfg_r <= rx_in.data;
        if (deliver && !rx_void_r && !rx_in.invalid_packet_marker)
        begin
          cli_rx_r <= '{1'b1, rx_in.data, rx_in.last};
          if (rx_end)
          begin
            cli_rx_good_r <= frame_ok && (rx_da_ok_r || grp_nxt || promisc);
            cli_rx_bad_r <= !(frame_ok && (rx_da_ok_r || grp_nxt || promisc));
          end
        end
        if (rx_end)
        begin
          rx_cnt_r <= '0;
          rx_crc_r <= `DPMF_CRC_INIT;
          rx_bad_r <= 1'b0;
          rx_da_ok_r <= 1'b1;
          rx_void_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Training and access state machine
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_r <= ST_TREQ;
      run_r <= '0;
      tries_r <= '0;
      wait_r <= '0;
    end
    else
    begin
      case (st_r)
        ST_TREQ:
        begin
          run_r <= '0;
          tries_r <= '0;
          if (link_in.rcs == RCS_TRAINING_DOWN)
            st_r <= ST_TGRANT;
        end
        ST_TGRANT:
          if (go_train)
            st_r <= ST_TSEND;
        ST_TSEND:
          if (tx_done)
            st_r <= ST_TRECV;
        ST_TRECV:
          if (rx_end && frame_ok)
          begin
            run_r <= run_r + 5'd1;
            if (run_r == `DPMF_TRAIN_GOOD_RUN - 5'd1)
              st_r <= (!acfg_r[`DPMF_ACFG_C_BIT] && !acfg_r[`DPMF_ACFG_N_BIT] &&
                       station_addr != 48'h0) ? ST_TDONE : ST_RETRAIN;
            else
              st_r <= ST_TGRANT;
          end
          else if (rx_end)
          begin
            run_r <= '0;
            tries_r <= tries_r + 6'd1;
            st_r <= (tries_r == 6'(TRAIN_TRIES_MAX - 1)) ? ST_RETRAIN : ST_TGRANT;
          end
        ST_TDONE:
          if (link_in.rcs == RCS_IDLE_DOWN || incoming)
            st_r <= ST_ACTIVE;
        ST_RETRAIN:
        begin
          // Minimum of the one-to-two second window, the safe end
          wait_r <= wait_r + 27'd1;
          if (wait_r == 27'(RETRAIN_CYCLES - 1))
          begin
            wait_r <= '0;
            st_r <= ST_TREQ;
          end
        end
        ST_ACTIVE:
          if (link_in.rcs == RCS_LINK_WARNING)
            st_r <= ST_TREQ;
          else if (incoming)
            st_r <= ST_DRECV;
          else if (go_data)
            st_r <= ST_DSEND;
        ST_DSEND:
          if (tx_done)
            st_r <= ST_ACTIVE;
        ST_DRECV:
          if (rx_end || link_in.rcs == RCS_IDLE_DOWN)
            st_r <= ST_ACTIVE;
        default:
          st_r <= ST_TREQ;
      endcase
    end
  end

  // ==========================================================
  // Link control outputs
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      tcs_r <= TCS_TRAINING_UP;
      rx_en_r <= 1'b0;
      trained_r <= 1'b0;
    end
    else
    begin
      trained_r <= st_r == ST_ACTIVE || st_r == ST_DSEND || st_r == ST_DRECV;
      rx_en_r <= st_r == ST_TRECV || st_r == ST_DRECV ||
                 (st_r == ST_ACTIVE && incoming);
      case (st_r)
        ST_TDONE:
          tcs_r <= TCS_IDLE_UP;
        ST_ACTIVE, ST_DSEND, ST_DRECV:
          tcs_r <= !cli_tx_req ? TCS_IDLE_UP :
                   cli_tx_high ? TCS_REQ_HIGH : TCS_REQ_NORMAL;
        default:
          tcs_r <= TCS_TRAINING_UP;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_train_len_max: assert property (ph_r == PH_DATA |-> cnt_r < `DPMF_TRAIN_LEN_MAX)
    else $error("training data field too long");
  a_train_len_min: assert property (ph_r == PH_FCS && train_r && cnt_r == 10'd0 |->
    $past(cnt_r) >= `DPMF_TRAIN_LEN_MIN - 10'd1) else $error("training data field too short");
  a_tail_zero: assert property (ph_r == PH_DATA && cnt_r >= `DPMF_PRIV_OCTETS |=>
    pmi_tx_r.valid && pmi_tx_r.data == 8'h0) else $error("training tail not zero");
  a_priv_off_zero: assert property (ph_r == PH_DATA && !priv_en |=>
    pmi_tx_r.data == 8'h0) else $error("private octet sent while disabled");
  a_priv_id_first: assert property (ph_r == PH_DATA && priv_en && cnt_r == 10'd0 |=>
    pmi_tx_r.data == priv_id[39:32]) else $error("identifier not first");
  a_grant_start: assert property (ph_r == PH_IDLE ##1 ph_r == PH_HDR |->
    $past(link_in.grant) && grant_used_r) else $error("send without fresh grant");
  a_one_per_grant: assert property (tx_done && link_in.grant |=>
    !go_data && !go_train) else $error("second packet on one grant");
  a_fcs_order: assert property (ph_r == PH_FCS |=>
    pmi_tx_r.data == dpmf_fcs_octet($past(crc_r), $past(cnt_r[1:0])))
    else $error("check octet out of order");
  a_req_pri: assert property (st_r == ST_ACTIVE && cli_tx_req && cli_tx_high |=>
    tcs_r == TCS_REQ_HIGH) else $error("priority request mismatch");
  a_rx_enable: assert property (st_r == ST_ACTIVE && incoming &&
    link_in.rcs != RCS_LINK_WARNING |=> rx_en_r ##1 rx_en_r) else $error("no receive mode");
  a_run_break: assert property (st_r == ST_TRECV && rx_end && !frame_ok |=>
    run_r == 5'd0) else $error("errored frame kept run");
  a_idle_up: assert property (st_r == ST_TDONE |=> tcs_r == TCS_IDLE_UP)
    else $error("idle-up missing after training");
  a_retrain_wait: assert property (st_r == ST_RETRAIN &&
    wait_r != 27'(RETRAIN_CYCLES - 1) |=> st_r == ST_RETRAIN) else $error("retrain too soon");
  a_void_drop: assert property (rx_in.valid && rx_in.invalid_packet_marker |=>
    !cli_rx_r.valid && !cli_rx_good_r) else $error("void frame delivered");

  c_trained: cover property (st_r == ST_TDONE ##1 st_r == ST_ACTIVE);
  c_data_sent: cover property (st_r == ST_DSEND && tx_done);
  c_good_rx: cover property (cli_rx_good_r);
  c_retrain: cover property (st_r == ST_RETRAIN);
endmodule : dpmf_framer
`default_nettype wire

//--- sim/dpmf_rep.sv
// Repeater access-control model facing the framer
`timescale 1ns/100ps
`default_nettype none
`include "dpmf_regs.svh"
module dpmf_rep
  import dpmf_pkg::*;
(
  input wire logic ref_clk,
  input wire dpmf_byte_t pmi_tx_r,
  output dpmf_link_t link_in,
  output dpmf_rx_t rx_in
);
  logic [7:0] cap[$];
  int n_fr = 0;
  bit inf = 0;
  initial link_in = '{RCS_TRAINING_DOWN, 1'b0};
  initial rx_in = '0;
  // ====================
  // Capture of sent frames
  always @(posedge ref_clk)
    if (pmi_tx_r.valid)
    begin
      if (!inf)
        cap.delete();
      cap.push_back(pmi_tx_r.data);
      inf = !pmi_tx_r.last;
      n_fr += int'(pmi_tx_r.last);
    end
  // ====================
  // Check value and link
  function automatic logic [31:0] crc(logic [31:0] c, logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? `DPMF_CRC_POLY : 32'h0);
    return c;
  endfunction : crc
  // Kind 1 flags a mid-frame error, 2 marks a void frame, 3 spoils the check field
  task automatic send(input logic [7:0] f[$], input int kind);
    logic [31:0] c;
    logic [7:0] b;
    c = `DPMF_CRC_INIT;
    foreach (f[i])
      c = crc(c, f[i]);
    c = ~c ^ ((kind == 3) ? 32'h1 : 32'h0);
    for (int k = 0; k < 32; k += 8)
    begin
      for (int j = 0; j < 8; j++)
        b[j] = c[31-k-j];
      f.push_back(b);
    end
    foreach (f[i])
    begin
      @(negedge ref_clk);
      rx_in = '{1'b1, f[i], i == f.size() - 1, kind == 1 && i == 8, kind == 2};
    end
    @(negedge ref_clk);
    // Released line shows the inverse so a stale octet never looks valid
    rx_in = '{1'b0, ~rx_in.data, 1'b0, 1'b0, 1'b0};
  endtask : send
  task automatic grant(input bit g);
    @(negedge ref_clk);
    link_in.grant = g;
  endtask : grant
  task automatic set_rcs(input dpmf_rcs_t r);
    @(negedge ref_clk);
    link_in.rcs = r;
  endtask : set_rcs
endmodule : dpmf_rep
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench of the end-node framer
`timescale 1ns/100ps
`default_nettype none
`include "dpmf_regs.svh"
module testbench
  import dpmf_pkg::*;
;
  typedef logic [7:0] dpmf_bq_t[$];
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [47:0] station_addr = 48'h02a4c3115e70;
  logic [15:0] req_cfg = 16'h2821;
  logic [9:0] train_len = 10'h252;
  logic priv_en = 1'b0;
  logic [39:0] priv_id = 40'h0;
  logic [5:0] priv_used = 6'h00;
  logic [7:0] priv_byte;
  logic promisc = 1'b0;
  logic cli_tx_req = 1'b0;
  logic cli_tx_high = 1'b0;
  logic cli_tx_fmt_tr = 1'b0;
  logic [15:0] cli_tx_prefix = 16'h0;
  logic [47:0] cli_tx_da = 48'h0;
  logic cli_tx_sa_valid = 1'b0;
  logic [47:0] cli_tx_sa = 48'h0;
  dpmf_byte_t cli_tx = '0;
  dpmf_link_t link_in;
  dpmf_rx_t rx_in;
  logic cli_tx_ready_r, rx_en_r, cli_rx_good_r, cli_rx_bad_r, trained_r;
  logic [5:0] priv_idx_r;
  dpmf_byte_t pmi_tx_r, cli_rx_r;
  dpmf_tcs_t tcs_r;
  logic [31:0] seed = 32'h00004b1d;
  int n_errors = 0, checked = 0, n_good = 0, n_bad = 0, n_del = 0, nf = 0, g0, b0, d0;
  dpmf_bq_t q, pay, e, rxq;

  dpmf_framer #(.RETRAIN_CYCLES(20)) u_dut (
    .ref_clk, .sys_rst, .station_addr, .req_cfg, .train_len, .priv_en, .priv_id,
    .priv_used, .priv_byte, .promisc, .cli_tx_req, .cli_tx_high, .cli_tx_fmt_tr,
    .cli_tx_prefix, .cli_tx_da, .cli_tx_sa_valid, .cli_tx_sa, .cli_tx, .link_in, .rx_in,
    .cli_tx_ready_r, .priv_idx_r, .pmi_tx_r, .tcs_r, .rx_en_r, .cli_rx_r, .cli_rx_good_r,
    .cli_rx_bad_r, .trained_r
  );
  dpmf_rep u_rep (.ref_clk, .pmi_tx_r, .link_in, .rx_in);

  always #5 ref_clk = ~ref_clk;
  function automatic logic [7:0] pb(int k);
    return 8'(k) ^ 8'ha5;
  endfunction : pb
  assign priv_byte = pb(int'(priv_idx_r));
  always @(posedge ref_clk)
  begin
    n_good += int'(cli_rx_good_r === 1'b1);
    n_bad += int'(cli_rx_bad_r === 1'b1);
    n_del += int'(cli_rx_r.valid === 1'b1);
    if (cli_rx_r.valid === 1'b1)
      rxq.push_back(cli_rx_r.data);
  end
  // ====================
  // Helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic void put(ref dpmf_bq_t b, input logic [47:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      b.push_back(v[8*i +: 8]);
  endfunction : put
  function automatic logic [7:0] tdat(int d);
    if (!priv_en || d >= 55)
      return 8'h00;
    if (d < 5)
      return priv_id[39-8*d -: 8];
    return (d - 5 < priv_used) ? pb(d - 5) : 8'h00;
  endfunction : tdat
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_frame(input dpmf_bq_t x);
    logic [31:0] c;
    c = `DPMF_CRC_INIT;
    chk(u_rep.cap.size(), x.size() + 4);
    foreach (x[i])
      chk(u_rep.cap[i], x[i]);
    foreach (u_rep.cap[i])
      c = u_rep.crc(c, u_rep.cap[i]);
    chk(c, `DPMF_CRC_RESIDUE);
  endtask : chk_frame
  task automatic xmit();
    int n0;
    n0 = u_rep.n_fr;
    repeat (rnd() % 6) @(negedge ref_clk);
    u_rep.grant(1'b1);
    while (u_rep.n_fr == n0) @(negedge ref_clk);
  endtask : xmit
  task automatic feed();
    int i;
    bit tk;
    i = 0;
    while (i < pay.size())
    begin
      cli_tx = '{rnd() % 4 != 0, pay[i], i == pay.size() - 1};
      tk = cli_tx_ready_r === 1'b1;
      @(negedge ref_clk);
      if (tk && cli_tx.valid)
        i++;
    end
    cli_tx = '0;
    cli_tx_req = 1'b0;
  endtask : feed
  task automatic finish_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // ====================
  // Main sequence
  initial
  begin
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk(tcs_r, TCS_TRAINING_UP);
    // Pass 3 errs and breaks the run; pass 27 refuses the configuration, forcing a retrain
    for (int it = 0; it < 52; it++)
    begin
      train_len = (it == 0) ? 10'h252 : (it == 1) ? 10'h2a3 : 10'h252 + 10'(rnd() % 82);
      priv_en = it % 3 != 0;
      priv_used = 6'(rnd() % 51);
      priv_id = {rnd() | 32'h80000000, 8'h5d};
      chk(trained_r, 1'b0);
      chk(tcs_r, TCS_TRAINING_UP);
      xmit();
      u_rep.grant(1'b0);
      e = {};
      put(e, 48'h0, 6);
      put(e, station_addr, 6);
      put(e, 48'(req_cfg), 2);
      put(e, 48'h0, 2);
      for (int d = 0; d < train_len; d++)
        e.push_back(tdat(d));
      chk_frame(e);
      q = u_rep.cap[0:$-4];
      repeat (4) q.push_back(8'(rnd()));
      if (it == 27)
        q[15] = 8'h02;
      repeat (3) @(negedge ref_clk);
      u_rep.send(q, (it == 3) ? 1 : 0);
      repeat (4) @(negedge ref_clk);
    end
    chk(tcs_r, TCS_IDLE_UP);
    u_rep.set_rcs(RCS_IDLE_DOWN);
    repeat (4) @(negedge ref_clk);
    chk(trained_r, 1'b1);
    nf = u_rep.n_fr;
    for (int m = 0; m < 6; m++)
    begin
      cli_tx_high = m % 2;
      cli_tx_fmt_tr = m / 2 == 1;
      cli_tx_sa_valid = m >= 4;
      cli_tx_prefix = 16'(rnd());
      cli_tx_da = {16'(rnd()), rnd()};
      cli_tx_sa = {16'(rnd()), rnd()};
      pay = {};
      repeat (1 + rnd() % 8) pay.push_back(8'(rnd()));
      cli_tx_req = 1'b1;
      repeat (10) @(negedge ref_clk);
      chk(u_rep.n_fr, nf);
      u_rep.grant(1'b0);
      repeat (3) @(negedge ref_clk);
      chk(tcs_r, (m % 2) ? TCS_REQ_HIGH : TCS_REQ_NORMAL);
      e = {};
      if (cli_tx_fmt_tr)
        put(e, 48'(cli_tx_prefix), 2);
      put(e, cli_tx_da, 6);
      put(e, cli_tx_sa_valid ? cli_tx_sa : station_addr, 6);
      e = {e, pay};
      fork
        xmit();
        feed();
      join
      chk_frame(e);
      nf = u_rep.n_fr;
    end
    u_rep.grant(1'b0);
    repeat (3) @(negedge ref_clk);
    chk(tcs_r, TCS_IDLE_UP);
    // Kinds: good, error flag, void, spoilt check, foreign unicast, group
    for (int k = 0; k < 6; k++)
    begin
      q = {};
      put(q, (k == 4) ? 48'h0a0b0c0d0e0f : (k == 5) ? 48'h01005e000001 : station_addr, 6);
      put(q, {16'(rnd()), rnd()}, 6);
      put(q, {16'(rnd()), rnd()}, 6);
      g0 = n_good;
      b0 = n_bad;
      d0 = n_del;
      u_rep.set_rcs(RCS_INCOMING);
      repeat (3) @(negedge ref_clk);
      chk(rx_en_r, 1'b1);
      rxq = {};
      u_rep.send(q, (k < 4) ? k : 0);
      u_rep.set_rcs(RCS_IDLE_DOWN);
      repeat (4) @(negedge ref_clk);
      chk(n_good - g0, (k == 0 || k == 5) ? 1 : 0);
      chk(n_bad - b0, (k == 0 || k == 2 || k == 5) ? 0 : 1);
      chk(n_del - d0, (k == 2) ? 0 : 22);
      if (k != 2)
        foreach (q[i])
          chk(rxq[i], q[i]);
    end
    // A link warning in active mode drops back to training
    u_rep.set_rcs(RCS_LINK_WARNING);
    repeat (3) @(negedge ref_clk);
    chk(trained_r, 1'b0);
    chk(tcs_r, TCS_TRAINING_UP);
    finish_test();
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
